// [rtl/lgc_link_if.sv]
// Interface: control and status between the bank and one link monitor
`timescale 1ns/100ps
interface lgc_link_if;
   logic rejoin_en;
   logic remove_en;
   logic seq_good;
   logic seq_excess;
   logic frame_edge;
   logic frame_lock;
   logic link_ok;
   logic seq_fail;

   // Monitor side
   modport mon (
      input rejoin_en, remove_en, seq_good, seq_excess, frame_edge,
      input frame_lock,
      output link_ok, seq_fail
   );

   // Register bank side
   modport ctl (
      output rejoin_en, remove_en, seq_good, seq_excess, frame_edge,
      output frame_lock,
      input link_ok, seq_fail
   );
endinterface

// [rtl/lgc_link_mon.sv]
// Module: receive link good tracker for one link
`timescale 1ns/100ps
module lgc_link_mon (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link control and status
   lgc_link_if.mon lnk
);
   lgc_pkg::lgc_link_state_e state;
   logic [1:0] good_cnt;
   logic [1:0] err_cnt;
   logic first_up;
   logic good_run;
   logic fail_run;

   // Three good in a row, or a third excessive error while up, counting the event of this cycle
   assign good_run = (good_cnt == lgc_pkg::SEQ_GOOD_RUN) ||
                     (lnk.seq_good && good_cnt == 2'h2);
   assign fail_run = lnk.seq_excess && (err_cnt == 2'h2);

   // Link state; rises only at a framing boundary, falls anywhere
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= lgc_pkg::LS_DOWN;
         first_up <= 1'b1;
         lnk.link_ok <= 1'b0;
         lnk.seq_fail <= 1'b0;
      end else begin
         case (state)
            lgc_pkg::LS_DOWN: begin
               // First lock needs no rejoin; later ones need rejoin on
               if (lnk.frame_edge && lnk.frame_lock &&
                   (first_up || (lnk.rejoin_en && good_run))) begin
                  state <= lgc_pkg::LS_UP;
                  first_up <= 1'b0;
                  lnk.link_ok <= 1'b1;
                  lnk.seq_fail <= 1'b0;
               end
            end
            lgc_pkg::LS_UP: begin
               if (!lnk.frame_lock) begin
                  state <= lgc_pkg::LS_DOWN;
                  lnk.link_ok <= 1'b0;
               end else if (lnk.remove_en && fail_run) begin
                  state <= lgc_pkg::LS_DOWN;
                  lnk.link_ok <= 1'b0;
                  lnk.seq_fail <= 1'b1;
               end
            end
            default: begin
               state <= lgc_pkg::LS_DOWN;
               lnk.link_ok <= 1'b0;
            end
         endcase
      end
   end

   // Consecutive correct sequence numbers, cleared by any error
   always_ff @(posedge clk) begin
      if (!rstn || state == lgc_pkg::LS_UP || !lnk.frame_lock) begin
         good_cnt <= 2'h0;
      end else if (lnk.seq_excess) begin
         good_cnt <= 2'h0;
      end else if (lnk.seq_good && good_cnt != lgc_pkg::SEQ_GOOD_RUN) begin
         good_cnt <= good_cnt + 2'h1;
      end
   end

   // Excessive sequence errors seen while the link is up
   always_ff @(posedge clk) begin
      if (!rstn || state == lgc_pkg::LS_DOWN) begin
         err_cnt <= 2'h0;
      end else if (lnk.seq_excess && err_cnt != lgc_pkg::SEQ_FAIL_RUN) begin
         err_cnt <= err_cnt + 2'h1;
      end
   end
endmodule // lgc_link_mon

// [rtl/lgc_pkg.sv]
// Package: constants and types of the link group control register bank
package lgc_pkg;
   // Register bus geometry
   localparam int ADDR_W = 18;
   localparam int DATA_W = 8;
   localparam int NUM_LINKS = 4;

   // Register offsets
   localparam logic [17:0] OFS_MEMBERSHIP = 18'h30a03;
   localparam logic [17:0] OFS_RESYNC = 18'h30a04;
   localparam logic [17:0] OFS_LINK_STATUS = 18'h30a10;

   // Values after reset
   localparam logic [7:0] RST_MEMBERSHIP = 8'h00;
   localparam logic [7:0] RST_RESYNC = 8'h00;

   // Writable bits; reserved bits store nothing and read as zero
   localparam logic [7:0] MASK_MEMBERSHIP = 8'hdb;
   localparam logic [7:0] MASK_RESYNC = 8'ha4;

   // Field positions in the membership register
   localparam int BIT_TX_SUPPRESS = 0;
   localparam int BIT_AUTO_BUNDLE = 1;
   localparam int BIT_REJOIN_A = 3;
   localparam int BIT_REMOVE_A = 4;
   localparam int BIT_REJOIN_B = 6;
   localparam int BIT_REMOVE_B = 7;

   // Field positions in the resync register
   localparam int BIT_REALIGN_B = 2;
   localparam int BIT_REALIGN_A = 5;
   localparam int BIT_REALIGN_QUAD = 7;

   // Link indices: block A lanes 0 and 1, then block B lanes 0 and 1
   localparam int LINK_A0 = 0;
   localparam int LINK_A1 = 1;
   localparam int LINK_B0 = 2;
   localparam int LINK_B1 = 3;

   // Run lengths for rejoin and removal
   localparam logic [1:0] SEQ_GOOD_RUN = 2'h3;
   localparam logic [1:0] SEQ_FAIL_RUN = 2'h3;

   // Link state of the receive monitor
   typedef enum logic {LS_DOWN, LS_UP} lgc_link_state_e;
endpackage

// [rtl/lgc_regs.sv]
// Module: link group membership and multichannel resync control bank
`timescale 1ns/100ps
module lgc_regs (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // Register port
   input wire logic [17:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // Receive link events from the framers, one bit per link
   input wire logic [3:0] SEQ_GOOD,
   input wire logic [3:0] SEQ_EXCESS,
   input wire logic [3:0] FRAME_EDGE,
   input wire logic [3:0] FRAME_LOCK,
   // Receive cells toward the fabric
   input wire logic [3:0] RX_CELL_VALID,
   output logic [3:0] RX_READ_EN,
   output logic [3:0] FABRIC_CELL_VALID,
   // Transmit links
   input wire logic [3:0] TX_DATA_VALID,
   output logic [3:0] TX_SEND_EN,
   output logic [3:0] TX_LINK_VALID,
   // Multichannel alignment
   input wire logic [3:0] ALIGN_CFG,
   output logic [3:0] REALIGN,
   // Link status
   output logic [3:0] RECEIVE_LINK_OK
);
   // Software registers
   logic [7:0] membership;
   logic [7:0] resync;
   logic [7:0] resync_prev;

   // Decoded strobes
   logic wr_membership;
   logic wr_resync;

   // Control fields
   logic tx_suppress_on_seq_fail;
   logic auto_bundle;
   logic [3:0] rejoin_en;
   logic [3:0] remove_en;

   // Edge pulses of the realign commands
   logic block_a_pair_realign;
   logic block_b_pair_realign;
   logic quad_channel_realign;

   // Monitor outputs
   logic [3:0] link_ok;
   logic [3:0] seq_fail;

   // Delivery decision per link, before the output flops
   logic [3:0] next_read_en;
   logic [3:0] next_send_en;
   logic [3:0] next_realign;

   // Link group test used for both serdes blocks
   function automatic logic [1:0] group_enable(
      input logic [1:0] ok,
      input logic bundle
   );
      logic [1:0] en;
      en = 2'h0;
      if (bundle) begin
         en = ok;
      end else if (ok == 2'h3) begin
         en = 2'h3;
      end
      return en;
   endfunction

   // Address decode shared by writes
   assign wr_membership = REG_WR && (REG_ADDR == lgc_pkg::OFS_MEMBERSHIP);
   assign wr_resync = REG_WR && (REG_ADDR == lgc_pkg::OFS_RESYNC);

   // Field extraction
   assign tx_suppress_on_seq_fail = membership[lgc_pkg::BIT_TX_SUPPRESS];
   assign auto_bundle = membership[lgc_pkg::BIT_AUTO_BUNDLE];
   assign rejoin_en = {{2{membership[lgc_pkg::BIT_REJOIN_B]}},
                       {2{membership[lgc_pkg::BIT_REJOIN_A]}}};
   assign remove_en = {{2{membership[lgc_pkg::BIT_REMOVE_B]}},
                       {2{membership[lgc_pkg::BIT_REMOVE_A]}}};

   // Membership register; reserved bits are dropped on write
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         membership <= lgc_pkg::RST_MEMBERSHIP;
      end else if (wr_membership) begin
         membership <= REG_WDATA & lgc_pkg::MASK_MEMBERSHIP;
      end
   end

   // Resync register; commands act on edges, so the level is kept
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         resync <= lgc_pkg::RST_RESYNC;
      end else if (wr_resync) begin
         resync <= REG_WDATA & lgc_pkg::MASK_RESYNC;
      end
   end

   // Previous resync value for edge detection
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         resync_prev <= lgc_pkg::RST_RESYNC;
      end else begin
         resync_prev <= resync;
      end
   end

   // Rising edges only; rewriting a one gives nothing, hence zero first
   assign block_b_pair_realign = resync[lgc_pkg::BIT_REALIGN_B] &&
      !resync_prev[lgc_pkg::BIT_REALIGN_B];
   assign block_a_pair_realign = resync[lgc_pkg::BIT_REALIGN_A] &&
      !resync_prev[lgc_pkg::BIT_REALIGN_A];
   assign quad_channel_realign = resync[lgc_pkg::BIT_REALIGN_QUAD] &&
      !resync_prev[lgc_pkg::BIT_REALIGN_QUAD];

   // Read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            lgc_pkg::OFS_MEMBERSHIP: begin
               REG_RDATA <= membership;
            end
            lgc_pkg::OFS_RESYNC: begin
               REG_RDATA <= resync;
            end
            lgc_pkg::OFS_LINK_STATUS: begin
               REG_RDATA <= {seq_fail, link_ok};
            end
            default: begin
               REG_RDATA <= 8'h00; // Unmapped reads answer zero
            end
         endcase
      end else begin
         REG_RDATA <= 8'h00;
      end
   end

   // One monitor per link, joined by an interface each
   genvar gi;
   generate
      for (gi = 0; gi < lgc_pkg::NUM_LINKS; gi++) begin : g_link
         lgc_link_if lnk_if ();

         // Drive the monitor from the bank and the framers
         assign lnk_if.rejoin_en = rejoin_en[gi];
         assign lnk_if.remove_en = remove_en[gi];
         assign lnk_if.seq_good = SEQ_GOOD[gi];
         assign lnk_if.seq_excess = SEQ_EXCESS[gi];
         assign lnk_if.frame_edge = FRAME_EDGE[gi];
         assign lnk_if.frame_lock = FRAME_LOCK[gi];
         assign link_ok[gi] = lnk_if.link_ok;
         assign seq_fail[gi] = lnk_if.seq_fail;

         lgc_link_mon u_mon (
            .clk(SYS_CLK),
            .rstn(RESETN),
            .lnk(lnk_if.mon)
         );
      end
   endgenerate

   // Group membership per serdes block; each block is one link group
   always_comb begin
      next_read_en = 4'h0;
      next_read_en[lgc_pkg::LINK_A1:lgc_pkg::LINK_A0] =
         group_enable(link_ok[lgc_pkg::LINK_A1:lgc_pkg::LINK_A0],
                      auto_bundle);
      next_read_en[lgc_pkg::LINK_B1:lgc_pkg::LINK_B0] =
         group_enable(link_ok[lgc_pkg::LINK_B1:lgc_pkg::LINK_B0],
                      auto_bundle);
   end

   // Transmit hold only for failures caused by sequence errors
   always_comb begin
      if (tx_suppress_on_seq_fail) begin
         next_send_en = ~seq_fail;
      end else begin
         next_send_en = 4'hf;
      end
   end

   // Realign requests reach only channels set up for alignment
   always_comb begin
      next_realign = 4'h0;
      if (quad_channel_realign) begin
         next_realign = 4'hf;
      end
      if (block_a_pair_realign) begin
         next_realign[lgc_pkg::LINK_A1:lgc_pkg::LINK_A0] = 2'h3;
      end
      if (block_b_pair_realign) begin
         next_realign[lgc_pkg::LINK_B1:lgc_pkg::LINK_B0] = 2'h3;
      end
      next_realign = next_realign & ALIGN_CFG;
   end

   // Receive side output flops
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         RX_READ_EN <= 4'h0;
         FABRIC_CELL_VALID <= 4'h0;
         RECEIVE_LINK_OK <= 4'h0;
      end else begin
         RX_READ_EN <= next_read_en;
         // Cells pass a cycle late; the enable is taken from this cycle
         FABRIC_CELL_VALID <= RX_CELL_VALID & next_read_en;
         RECEIVE_LINK_OK <= link_ok;
      end
   end

   // Transmit side output flops
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         TX_SEND_EN <= 4'h0;
         TX_LINK_VALID <= 4'h0;
      end else begin
         TX_SEND_EN <= next_send_en;
         TX_LINK_VALID <= TX_DATA_VALID & next_send_en;
      end
   end

   // Realign pulses, one cycle each
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         REALIGN <= 4'h0;
      end else begin
         REALIGN <= next_realign;
      end
   end
endmodule // lgc_regs

// [testbench/lgc_far_end.sv]
// Partner model: framers and fabric around the control bank
`timescale 1ns/100ps
module lgc_far_end (
   // Clock
   input wire logic clk,
   // Framer events and levels
   output logic [3:0] seq_good,
   output logic [3:0] seq_excess,
   output logic [3:0] frame_edge,
   output logic [3:0] frame_lock,
   // Cell traffic, random every cycle
   output logic [3:0] rx_cell_valid,
   output logic [3:0] tx_data_valid
);
   int seed = 32'h7a736eda;
   function automatic logic [7:0] rnd();
      return 8'($random(seed));
   endfunction
   // Known levels at time zero
   initial begin
      {seq_good, seq_excess, frame_edge, frame_lock} = '0;
      {rx_cell_valid, tx_data_valid} = '0;
   end
   // Traffic changes each cycle so stale gating shows up at once
   always @(posedge clk) begin
      rx_cell_valid <= 4'(rnd());
      tx_data_valid <= 4'(rnd());
   end
   // One-cycle event burst, then a quiet cycle
   task automatic ev(input logic [3:0] g, e, f);
      @(posedge clk);
      seq_good <= g;
      seq_excess <= e;
      frame_edge <= f;
      @(posedge clk);
      {seq_good, seq_excess, frame_edge} <= '0;
   endtask
   task automatic lock(input logic [3:0] v);
      @(posedge clk);
      frame_lock <= v;
   endtask
endmodule // lgc_far_end

// [testbench/lgc_monitor.sv]
// Checker: port assertions for the link group control bank
`timescale 1ns/100ps
module lgc_monitor (
   // Clock, reset and register port
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic [17:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   // Link side
   input wire logic [3:0] FRAME_EDGE,
   input wire logic [3:0] FRAME_LOCK,
   input wire logic [3:0] RX_CELL_VALID,
   input wire logic [3:0] RX_READ_EN,
   input wire logic [3:0] FABRIC_CELL_VALID,
   input wire logic [3:0] TX_DATA_VALID,
   input wire logic [3:0] TX_SEND_EN,
   input wire logic [3:0] TX_LINK_VALID,
   input wire logic [3:0] ALIGN_CFG,
   input wire logic [3:0] REALIGN,
   input wire logic [3:0] RECEIVE_LINK_OK
);
   logic [7:0] mem, rsy, mem_old, rsy_old, rise;
   logic [3:0] pmap, grp;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   // Shadow registers, so outputs can be tied to what software wrote
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         {mem, rsy, mem_old, rsy_old} <= '0;
      end else begin
         {mem_old, rsy_old} <= {mem, rsy};
         if (REG_WR && REG_ADDR == lgc_pkg::OFS_MEMBERSHIP) begin
            mem <= REG_WDATA & lgc_pkg::MASK_MEMBERSHIP;
         end
         if (REG_WR && REG_ADDR == lgc_pkg::OFS_RESYNC) begin
            rsy <= REG_WDATA & lgc_pkg::MASK_RESYNC;
         end
      end
   end
   // Expected pulses and group gating
   assign rise = rsy & ~rsy_old;
   assign pmap = {{2{rise[7] | rise[2]}}, {2{rise[7] | rise[5]}}};
   assign grp = mem_old[1] ? RECEIVE_LINK_OK :
      {{2{&RECEIVE_LINK_OK[3:2]}}, {2{&RECEIVE_LINK_OK[1:0]}}};
   // Data lag one cycle; the enable shown beside them is the one applied
   a_fabric_gate: assert property ($past(RESETN) |->
      FABRIC_CELL_VALID == ($past(RX_CELL_VALID) & RX_READ_EN))
      else $error("fabric valid not gated by read enable");
   a_tx_gate: assert property ($past(RESETN) |->
      TX_LINK_VALID == ($past(TX_DATA_VALID) & TX_SEND_EN))
      else $error("transmit valid not gated by send enable");
   a_send_free: assert property ($past(RESETN, 2) && !mem_old[0] |->
      TX_SEND_EN == 4'hf)
      else $error("send held while suppression off");
   a_send_good: assert property ($past(RESETN, 2) && mem_old[0] |->
      (TX_SEND_EN & RECEIVE_LINK_OK) == RECEIVE_LINK_OK)
      else $error("good link not sending");
   a_read_group: assert property (RX_READ_EN == grp)
      else $error("read enable breaks group rule");
   a_realign_edge: assert property (
      REALIGN == $past(pmap & ALIGN_CFG))
      else $error("realign pulse wrong");
   a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data outside read slot");
   a_rdata_value: assert property (
      $past(REG_RD && REG_ADDR != lgc_pkg::OFS_LINK_STATUS) |->
      REG_RDATA == ($past(REG_ADDR) == lgc_pkg::OFS_MEMBERSHIP ? mem_old :
      $past(REG_ADDR) == lgc_pkg::OFS_RESYNC ? rsy_old : 8'h00))
      else $error("read data wrong");
   a_ok_rise_frame: assert property ((RECEIVE_LINK_OK &
      ~$past(RECEIVE_LINK_OK) & ~$past(FRAME_EDGE & FRAME_LOCK, 2)) == 4'h0)
      else $error("link good rose off a frame edge");
   a_lock_loss: assert property ($past(RESETN, 2) |->
      (RECEIVE_LINK_OK & ~$past(FRAME_LOCK, 2)) == 4'h0)
      else $error("link good kept without lock");
endmodule // lgc_monitor

bind lgc_regs lgc_monitor u_mon (.SYS_CLK, .RESETN, .REG_ADDR, .REG_WDATA,
   .REG_WR, .REG_RD, .REG_RDATA, .FRAME_EDGE, .FRAME_LOCK, .RX_CELL_VALID,
   .RX_READ_EN, .FABRIC_CELL_VALID, .TX_DATA_VALID, .TX_SEND_EN,
   .TX_LINK_VALID, .ALIGN_CFG, .REALIGN, .RECEIVE_LINK_OK);

// [testbench/tb.sv]
// Testbench: link group control bank against a behavioural model
`timescale 1ns/100ps
module tb;
   logic SYS_CLK, RESETN, REG_WR, REG_RD;
   logic [17:0] REG_ADDR;
   logic [7:0] REG_WDATA, REG_RDATA, mem, rsy;
   logic [3:0] SEQ_GOOD, SEQ_EXCESS, FRAME_EDGE, FRAME_LOCK, ALIGN_CFG;
   logic [3:0] RX_CELL_VALID, RX_READ_EN, FABRIC_CELL_VALID, REALIGN;
   logic [3:0] TX_DATA_VALID, TX_SEND_EN, TX_LINK_VALID, RECEIVE_LINK_OK;
   logic [3:0] ok, fail;
   int num_errors = 0;
   int tests_run = 0;
   int rb[$] = '{2, 5, 7};
   int pm[$] = '{12, 3, 15};
   localparam logic [17:0] M = lgc_pkg::OFS_MEMBERSHIP;
   localparam logic [17:0] R = lgc_pkg::OFS_RESYNC;
   lgc_regs u_dut (.SYS_CLK, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR,
      .REG_RD, .REG_RDATA, .SEQ_GOOD, .SEQ_EXCESS, .FRAME_EDGE, .FRAME_LOCK,
      .RX_CELL_VALID, .RX_READ_EN, .FABRIC_CELL_VALID, .TX_DATA_VALID,
      .TX_SEND_EN, .TX_LINK_VALID, .ALIGN_CFG, .REALIGN, .RECEIVE_LINK_OK);
   lgc_far_end u_far (.clk(SYS_CLK), .seq_good(SEQ_GOOD),
      .seq_excess(SEQ_EXCESS), .frame_edge(FRAME_EDGE),
      .frame_lock(FRAME_LOCK), .rx_cell_valid(RX_CELL_VALID),
      .tx_data_valid(TX_DATA_VALID));
   // 250 MHz clock
   initial begin
      SYS_CLK = 0;
      forever #2 SYS_CLK = ~SYS_CLK;
   end
   task automatic chk_rd(input logic [7:0] g, e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_ln(input logic [3:0] g, e);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Register write, one strobe cycle; model keeps only writable bits
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge SYS_CLK);
      REG_WR <= 1'b0;
      if (a == M) mem = d & lgc_pkg::MASK_MEMBERSHIP;
      if (a == R) rsy = d & lgc_pkg::MASK_RESYNC;
   endtask
   task automatic rd(input logic [17:0] a, input logic [7:0] e);
      @(posedge SYS_CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge SYS_CLK);
      REG_RD <= 1'b0;
      #1 chk_rd(REG_RDATA, e);
   endtask
   // Settle, then compare link status, read and send enables
   task automatic links();
      logic [3:0] re, se, rxv, txv;
      repeat (2) @(posedge SYS_CLK);
      // Traffic that the next edge will gate
      #1 rxv = RX_CELL_VALID;
      txv = TX_DATA_VALID;
      @(posedge SYS_CLK);
      #1 re = mem[1] ? ok : {{2{&ok[3:2]}}, {2{&ok[1:0]}}};
      se = mem[0] ? ~fail : 4'hf;
      chk_ln(RECEIVE_LINK_OK, ok);
      chk_ln(RX_READ_EN, re);
      chk_ln(TX_SEND_EN, se);
      chk_ln(FABRIC_CELL_VALID, rxv & re);
      chk_ln(TX_LINK_VALID, txv & se);
   endtask
   task automatic end_of_test();
      $display("mismatches %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Watchdog well beyond the roughly 110 cycles the run needs
   initial begin
      repeat (3000) @(posedge SYS_CLK);
      num_errors++;
      end_of_test();
   end
   // Main sequence
   initial begin
      {REG_WR, REG_RD, REG_ADDR, REG_WDATA, ALIGN_CFG} = '0;
      {mem, rsy, ok, fail} = '0;
      RESETN = 1'b0;
      repeat (3) @(posedge SYS_CLK);
      RESETN <= 1'b1;
      rd(M, 8'h00);
      rd(R, 8'h00);
      links();
      wr(M, 8'hff);
      rd(M, 8'hdb);
      wr(18'h30a05, u_far.rnd());
      rd(18'h30a05, 8'h00);
      u_far.lock(4'hf);
      u_far.ev(4'h0, 4'h0, 4'hf);
      ok = 4'hf;
      links();
      repeat (3) u_far.ev(4'h0, 4'h5, 4'h0);
      ok = 4'ha;
      fail = 4'h5;
      links();
      wr(M, 8'hd9);
      links();
      wr(M, 8'hd8);
      links();
      repeat (3) u_far.ev(4'h5, 4'h0, 4'h0);
      u_far.ev(4'h0, 4'h0, 4'h5);
      ok = 4'hf;
      fail = 4'h0;
      links();
      wr(M, 8'h93);
      repeat (3) u_far.ev(4'h0, 4'h6, 4'h0);
      repeat (3) u_far.ev(4'h6, 4'h0, 4'h0);
      u_far.ev(4'h0, 4'h0, 4'h6);
      ok = 4'h9;
      fail = 4'h6;
      links();
      u_far.lock(4'h7);
      ok = 4'h1;
      links();
      rd(lgc_pkg::OFS_LINK_STATUS, {fail, ok});
      @(posedge SYS_CLK);
      ALIGN_CFG <= 4'(u_far.rnd());
      foreach (rb[k]) begin
         wr(R, 8'h00);
         wr(R, 8'h01 << rb[k]);
         @(posedge SYS_CLK);
         #1 chk_ln(REALIGN, 4'(pm[k]) & ALIGN_CFG);
         wr(R, 8'h01 << rb[k]);
         @(posedge SYS_CLK);
         #1 chk_ln(REALIGN, 4'h0);
      end
      wr(R, 8'hff);
      rd(R, rsy);
      end_of_test();
   end
endmodule // tb
